// *** hdl/ettxd_pkg.sv ***
/*
 * Shared constants and types for the transmit descriptor interpreter:
 * descriptor field positions, write-back offsets, the control register
 * map, state encodings and the structs carried between the modules.
 * Assumes normal four-word descriptors of 16 bytes each in system memory.
 */
package ettxd_pkg;

    // Word 0 control bits
    localparam int unsigned W0_OWN = 31;
    localparam int unsigned W0_LS = 29;
    localparam int unsigned W0_FS = 28;
    localparam int unsigned W0_STAMP_EN = 25;
    localparam int unsigned W0_END_RING = 21;
    localparam int unsigned W0_CHAIN = 20;

    // Word 1 fields
    localparam int unsigned W1_CHAIN = 24;
    localparam int unsigned SIZE_W = 13;
    localparam int unsigned BS1_LO = 0;
    localparam int unsigned BS2_LO = 16;

    // Byte offsets of descriptor words and descriptor stride
    localparam logic [31:0] W0_OFS = 32'h0000_0000;
    localparam logic [31:0] W2_OFS = 32'h0000_0008;
    localparam logic [31:0] W3_OFS = 32'h0000_000C;
    localparam logic [31:0] DESC_BYTES = 32'h0000_0010;

    // Control register map
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_RING = 5'h04;
    localparam logic [4:0] REG_STATUS = 5'h08;
    localparam logic [4:0] REG_NEXT = 5'h0C;
    localparam logic [4:0] REG_COUNT = 5'h10;
    localparam int unsigned CTRL_STAMP_EN = 0;
    localparam int unsigned CTRL_RUN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [31:0] RING_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [31:0] w3;
        logic [31:0] w2;
        logic [31:0] w1;
        logic [31:0] w0;
    } ettxd_desc_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [SIZE_W-1:0] size;
        logic last;
    } ettxd_seg_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } ettxd_mwr_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_SEG1 = 3'h1,
        S_SEG2 = 3'h3,
        S_WAIT = 3'h2,
        S_WB = 3'h6
    } ettxd_state_t;

    typedef enum logic [1:0] {
        WB_IDLE = 2'h0,
        WB_LOW = 2'h1,
        WB_HIGH = 2'h3,
        WB_OWN = 2'h2
    } ettxd_wb_state_t;

    // Buffer size field of word 1 starting at bit lo
    function automatic logic [SIZE_W-1:0] size_field(
        input logic [31:0] w, input int unsigned lo);
        return w[lo +: SIZE_W];
    endfunction

endpackage

// *** hdl/ettxd_wback.sv ***
/*
 * Descriptor write-back sequencer: optionally writes the two timestamp
 * words, then writes word 0 with ownership cleared.
 * Assumes the caller holds base, word0 and stamp steady until done.
 */
module ettxd_wback (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic with_stamp,
    input wire logic [31:0] base,
    input wire logic [31:0] word0,
    input wire logic [63:0] stamp,
    output logic mem_valid,
    input wire logic mem_ready,
    output ettxd_pkg::ettxd_mwr_t mem,
    output logic done
);
    import ettxd_pkg::*;

    ettxd_wb_state_t state_q, state_d;
    ettxd_mwr_t mem_q, mem_d;
    logic [31:0] own_cleared;

    // Only the ownership bit changes; every other bit goes back as fetched
    always_comb begin
        own_cleared = word0;
        own_cleared[W0_OWN] = 1'b0;
    end

    // Stamp words first, ownership last, so software never sees half
    always_comb begin
        state_d = state_q;
        mem_d = mem_q;
        unique case (state_q)
            WB_IDLE: begin
                if (start && with_stamp) begin
                    state_d = WB_LOW;
                    mem_d = '{addr: base + W2_OFS, data: stamp[31:0]};
                end else if (start) begin
                    state_d = WB_OWN;
                    mem_d = '{addr: base + W0_OFS, data: own_cleared};
                end
            end
            WB_LOW: begin
                if (mem_ready) begin
                    state_d = WB_HIGH;
                    mem_d = '{addr: base + W3_OFS, data: stamp[63:32]};
                end
            end
            WB_HIGH: begin
                if (mem_ready) begin
                    state_d = WB_OWN;
                    mem_d = '{addr: base + W0_OFS, data: own_cleared};
                end
            end
            WB_OWN: begin
                if (mem_ready) begin
                    state_d = WB_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= WB_IDLE;
            mem_q <= '0;
        end else begin
            state_q <= state_d;
            mem_q <= mem_d;
        end
    end

    assign mem_valid = (state_q != WB_IDLE);
    assign mem = mem_q;
    assign done = (state_q == WB_OWN) && mem_ready;

endmodule // ettxd_wback

// *** hdl/ettxd_core.sv ***
/*
 * Transmit descriptor interpreter: takes a fetched descriptor, issues
 * buffer segments from words 1 to 3, computes the next descriptor
 * address, waits for transmission and writes status back.
 * Assumes a fetch unit delivering descriptors, a data mover taking
 * segments, a MAC pulsing completion with the captured timestamp, and a
 * memory write port; all on sys_clk.
 */
// Notes on behaviour
// - Buffer one size is word 1 bits 12:0, and a zero size skips it.
// - Buffer two size is word 1 bits 28:16, ignored when chained.
// - Word 2 of an owned descriptor is the buffer one start address.
// - The buffer one address may have any byte alignment.
// - Word 2 receives the low stamp half for stamped last segments.
// - In a ring, word 3 of an owned descriptor is the buffer two address.
// - With word 1 bit 24 set, word 3 points to the next descriptor.
// - Word 3 receives the high stamp half for stamped last segments.
// - Word 0 bit 31 is ownership and is cleared when done.
// - Word 0 bit 20 makes word 3 the next descriptor address.
// - Word 0 bit 29 marks the last segment and gates stamp write-back.
// - Word 0 bit 25 with the global enable arms stamping at first segment.
module ettxd_core #(
    parameter int unsigned REG_AW = 5
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic desc_valid,
    output logic desc_ready,
    input wire logic [31:0] desc_addr,
    input wire ettxd_pkg::ettxd_desc_t desc,
    output logic seg_valid,
    input wire logic seg_ready,
    output ettxd_pkg::ettxd_seg_t seg,
    input wire logic tx_done,
    input wire logic [63:0] tx_stamp,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output ettxd_pkg::ettxd_mwr_t mem_wr,
    output logic next_valid,
    output logic [31:0] next_addr
);
    import ettxd_pkg::*;

    // Elaboration check: the register map needs five address bits
    if (REG_AW < 5) begin : g_aw_check
        $error("REG_AW must be at least 5");
    end

    // Register group
    logic [1:0] ctrl_q, ctrl_d;
    logic [31:0] ring_q, ring_d;
    logic [31:0] count_q, count_d;
    logic [31:0] rdata_q, rdata_d;
    logic suspended_q, suspended_d;

    // Descriptor group
    ettxd_state_t state_q, state_d;
    ettxd_desc_t desc_q, desc_d;
    logic [31:0] base_q, base_d;
    logic [31:0] next_q, next_d;
    ettxd_seg_t seg_q, seg_d;
    logic [63:0] stamp_q, stamp_d;
    logic stamp_act_q, stamp_act_d;
    logic issued_q, issued_d;
    logic wb_start_q, wb_start_d;
    logic next_valid_q, next_valid_d;

    logic wb_done;
    logic chained;
    logic skip2;
    logic accept;
    logic [SIZE_W-1:0] size1;
    logic [SIZE_W-1:0] size2;

    // Field decode of the held descriptor; bits 15:13 and 31:29 unused
    always_comb begin
        size1 = size_field(desc_q.w1, BS1_LO);
        size2 = size_field(desc_q.w1, BS2_LO);
        chained = desc_q.w0[W0_CHAIN] || desc_q.w1[W1_CHAIN];
        skip2 = chained || (size2 == '0);
    end

    assign accept = desc_valid && desc_ready;

    // Register access: writes steer the block, reads show its state
    always_comb begin
        ctrl_d = ctrl_q;
        ring_d = ring_q;
        rdata_d = '0;
        if (reg_wr && reg_addr == REG_AW'(REG_CTRL)) begin
            ctrl_d = reg_wdata[1:0];
        end
        if (reg_wr && reg_addr == REG_AW'(REG_RING)) begin
            ring_d = reg_wdata;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_AW'(REG_CTRL): rdata_d = {30'h0, ctrl_q};
                REG_AW'(REG_RING): rdata_d = ring_q;
                REG_AW'(REG_STATUS): rdata_d = {26'h0, issued_q,
                    stamp_act_q, suspended_q, state_q};
                REG_AW'(REG_NEXT): rdata_d = next_q;
                REG_AW'(REG_COUNT): rdata_d = count_q;
                default: rdata_d = '0; // Unmapped reads as zero
            endcase
        end
    end

    // Descriptor walk: buffer one, buffer two, wait, write-back
    always_comb begin
        state_d = state_q;
        desc_d = desc_q;
        base_d = base_q;
        next_d = next_q;
        seg_d = seg_q;
        stamp_d = stamp_q;
        stamp_act_d = stamp_act_q;
        issued_d = issued_q;
        wb_start_d = 1'b0;
        next_valid_d = 1'b0;
        suspended_d = suspended_q;
        count_d = count_q;
        unique case (state_q)
            S_IDLE: begin
                if (accept) begin
                    desc_d = desc;
                    base_d = desc_addr;
                    issued_d = 1'b0;
                    // Unowned descriptor suspends until the next fetch
                    suspended_d = !desc.w0[W0_OWN];
                    if (desc.w0[W0_OWN]) begin
                        state_d = S_SEG1;
                        // Address taken unaligned, no low bits dropped
                        seg_d.addr = desc.w2;
                        seg_d.size = size_field(desc.w1, BS1_LO);
                        seg_d.last = desc.w0[W0_LS] && desc.w0[W0_CHAIN];
                        if (desc.w0[W0_FS]) begin
                            stamp_act_d = desc.w0[W0_STAMP_EN]
                                && ctrl_q[CTRL_STAMP_EN];
                        end
                        // End of ring outranks chaining
                        if (desc.w0[W0_END_RING]) begin
                            next_d = ring_q;
                        end else if (desc.w0[W0_CHAIN]
                            || desc.w1[W1_CHAIN]) begin
                            next_d = desc.w3;
                        end else begin
                            next_d = desc_addr + DESC_BYTES;
                        end
                    end
                end
            end
            S_SEG1: begin
                if (size1 == '0 || seg_ready) begin
                    state_d = S_SEG2;
                    issued_d = issued_q || (size1 != '0);
                    seg_d.addr = desc_q.w3;
                    seg_d.size = size2;
                    seg_d.last = desc_q.w0[W0_LS];
                end
            end
            S_SEG2: begin
                if (skip2 || seg_ready) begin
                    // Both buffers empty: release without waiting
                    if (issued_q || !skip2) begin
                        state_d = S_WAIT;
                    end else begin
                        state_d = S_WB;
                        wb_start_d = 1'b1;
                    end
                end
            end
            S_WAIT: begin
                if (tx_done) begin
                    stamp_d = tx_stamp;
                    state_d = S_WB;
                    wb_start_d = 1'b1;
                end
            end
            S_WB: begin
                if (wb_done) begin
                    state_d = S_IDLE;
                    next_valid_d = 1'b1;
                    count_d = count_q + 32'h0000_0001;
                    if (desc_q.w0[W0_LS]) begin
                        stamp_act_d = 1'b0;
                    end
                end
            end
            default: begin
                state_d = S_IDLE; // Recover from an illegal code
            end
        endcase
    end

    // Register group storage
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
            ring_q <= RING_RESET;
            count_q <= '0;
            rdata_q <= '0;
            suspended_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            ring_q <= ring_d;
            count_q <= count_d;
            rdata_q <= rdata_d;
            suspended_q <= suspended_d;
        end
    end

    // Descriptor group storage
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= S_IDLE;
            desc_q <= '0;
            base_q <= '0;
            next_q <= '0;
            seg_q <= '0;
            stamp_q <= '0;
            stamp_act_q <= 1'b0;
            issued_q <= 1'b0;
            wb_start_q <= 1'b0;
            next_valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            desc_q <= desc_d;
            base_q <= base_d;
            next_q <= next_d;
            seg_q <= seg_d;
            stamp_q <= stamp_d;
            stamp_act_q <= stamp_act_d;
            issued_q <= issued_d;
            wb_start_q <= wb_start_d;
            next_valid_q <= next_valid_d;
        end
    end

    // Stamp words only for an armed frame on its last segment
    ettxd_wback u_wback (
        .sys_clk(sys_clk),
        .reset(reset),
        .start(wb_start_q),
        .with_stamp(stamp_act_q && desc_q.w0[W0_LS]),
        .base(base_q),
        .word0(desc_q.w0),
        .stamp(stamp_q),
        .mem_valid(mem_wr_valid),
        .mem_ready(mem_wr_ready),
        .mem(mem_wr),
        .done(wb_done)
    );

    // Handshakes combinational, data from flops
    assign desc_ready = (state_q == S_IDLE) && ctrl_q[CTRL_RUN];
    assign seg_valid = ((state_q == S_SEG1) && (size1 != '0))
        || ((state_q == S_SEG2) && !skip2);
    assign seg = seg_q;
    assign reg_rdata = rdata_q;
    assign next_valid = next_valid_q;
    assign next_addr = next_q;

endmodule // ettxd_core

// *** sim/ettxd_checker.sv ***
/* Port assertions for the transmit descriptor interpreter.
   Assumes descriptors start on 16-byte boundaries. */
module ettxd_checker (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic desc_valid,
    input wire logic desc_ready,
    input wire ettxd_pkg::ettxd_desc_t desc,
    input wire logic seg_valid,
    input wire logic seg_ready,
    input wire ettxd_pkg::ettxd_seg_t seg,
    input wire logic tx_done,
    input wire logic [63:0] tx_stamp,
    input wire logic mem_wr_valid,
    input wire logic mem_wr_ready,
    input wire ettxd_pkg::ettxd_mwr_t mem_wr,
    input wire logic next_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    import ettxd_pkg::*;
    logic [63:0] stamp_q;
    logic [63:0] stamp_d;
    logic acc;
    logic own;
    logic wr_acc;
    logic [3:0] wofs;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Stamp of the frame in flight, for the write-back compare
    always_comb begin
        stamp_d = tx_done ? tx_stamp : stamp_q;
    end
    always_ff @(posedge sys_clk) begin
        stamp_q <= reset ? 64'h0 : stamp_d;
    end
    assign acc = desc_valid && desc_ready;
    assign own = desc.w0[W0_OWN];
    assign wr_acc = mem_wr_valid && mem_wr_ready;
    assign wofs = mem_wr.addr[3:0];
    a_seg_first: assert property (acc && own && desc.w1[12:0] != 13'h0 |=>
        seg_valid && seg.addr == $past(desc.w2) && seg.size == $past(desc.w1[12:0]))
        else $error("first segment wrong");
    a_seg_nonzero: assert property (seg_valid |-> seg.size != 13'h0)
        else $error("zero sized segment");
    a_seg_hold: assert property (seg_valid && !seg_ready |=> seg_valid && $stable(seg))
        else $error("segment dropped");
    a_unowned_idle: assert property (acc && !own |=>
        desc_ready && !seg_valid && !mem_wr_valid) else $error("unowned used");
    a_owned_busy: assert property (acc && own |=> !desc_ready)
        else $error("ready while busy");
    a_wr_hold: assert property (mem_wr_valid && !mem_wr_ready |=>
        mem_wr_valid && $stable(mem_wr)) else $error("write dropped");
    a_stamp_low: assert property (wr_acc && wofs == 4'h8 |->
        mem_wr.data == stamp_q[31:0]) else $error("stamp low wrong");
    a_low_then_high: assert property (wr_acc && wofs == 4'h8 |=>
        mem_wr_valid && wofs == 4'hC && mem_wr.data == stamp_q[63:32])
        else $error("stamp high wrong");
    a_high_then_own: assert property (wr_acc && wofs == 4'hC |=>
        mem_wr_valid && wofs == 4'h0) else $error("release not after stamp");
    a_own_clear: assert property (wr_acc && wofs == 4'h0 |-> !mem_wr.data[31])
        else $error("ownership kept");
    a_release_late: assert property (next_valid |->
        $past(wr_acc) && $past(wofs) == 4'h0) else $error("early release");
endmodule // ettxd_checker

bind ettxd_core ettxd_checker chk (
    .sys_clk(sys_clk), .reset(reset), .desc_valid(desc_valid),
    .desc_ready(desc_ready), .desc(desc), .seg_valid(seg_valid),
    .seg_ready(seg_ready), .seg(seg), .tx_done(tx_done),
    .tx_stamp(tx_stamp), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr(mem_wr), .next_valid(next_valid)
);

// *** sim/ettxd_host.sv ***
/* Far side model: host memory taking write-back and a data mover
   taking segments. Both stall at random, as real memory does. */
module ettxd_host (
    input wire logic sys_clk,
    input wire logic seg_valid,
    output logic seg_ready,
    input wire ettxd_pkg::ettxd_seg_t seg,
    input wire logic mem_wr_valid,
    output logic mem_wr_ready,
    input wire ettxd_pkg::ettxd_mwr_t mem_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    import ettxd_pkg::*;
    logic [31:0] mem [logic [31:0]];
    ettxd_seg_t segq [$];
    initial begin
        seg_ready = 1'b0;
        mem_wr_ready = 1'b0;
    end
    // Random stalls so held requests get exercised
    always @(posedge sys_clk) begin
        seg_ready <= ($urandom % 3) != 0;
        mem_wr_ready <= ($urandom % 3) != 0;
        if (seg_valid && seg_ready) segq.push_back(seg);
        if (mem_wr_valid && mem_wr_ready) mem[mem_wr.addr] = mem_wr.data;
    end
endmodule // ettxd_host

// *** sim/tb_top.sv ***
/* Bench top: drives registers, descriptors and completions.
   Assumes the host model answers segments and write-back. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ettxd_pkg::*;
    localparam logic [31:0] RING_BASE = 32'h0000_4000;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic desc_valid = 1'b0;
    logic desc_ready;
    logic [31:0] desc_addr = 32'h0;
    ettxd_desc_t desc = '0;
    logic seg_valid;
    logic seg_ready;
    ettxd_seg_t seg;
    logic tx_done = 1'b0;
    logic [63:0] tx_stamp = 64'h0;
    logic mem_wr_valid;
    logic mem_wr_ready;
    ettxd_mwr_t mem_wr;
    logic next_valid;
    logic [31:0] next_addr;
    logic stamp_on = 1'b1;
    int error_cnt = 0;
    int total_checks = 0;
    ettxd_core #(.REG_AW(5)) uut (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .desc_valid(desc_valid),
        .desc_ready(desc_ready), .desc_addr(desc_addr), .desc(desc),
        .seg_valid(seg_valid), .seg_ready(seg_ready), .seg(seg),
        .tx_done(tx_done), .tx_stamp(tx_stamp),
        .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
        .mem_wr(mem_wr), .next_valid(next_valid), .next_addr(next_addr)
    );
    ettxd_host host (
        .sys_clk(sys_clk), .seg_valid(seg_valid), .seg_ready(seg_ready),
        .seg(seg), .mem_wr_valid(mem_wr_valid),
        .mem_wr_ready(mem_wr_ready), .mem_wr(mem_wr)
    );
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check32(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Ready is judged at the falling edge, away from the state update
    task automatic send(input logic [31:0] a, input ettxd_desc_t d);
        int n;
        n = 0;
        @(posedge sys_clk);
        desc_addr <= a;
        desc <= d;
        desc_valid <= 1'b1;
        @(negedge sys_clk);
        while (desc_ready !== 1'b1 && n++ < 200) @(negedge sys_clk);
        check32(32'(n > 200), 32'h0, "descriptor wait");
        @(posedge sys_clk);
        desc_valid <= 1'b0;
    endtask
    function automatic logic [31:0] nxt(input ettxd_desc_t d,
        input logic [31:0] a);
        if (d.w0[W0_END_RING]) return RING_BASE;
        if (d.w0[W0_CHAIN] | d.w1[W1_CHAIN]) return d.w3;
        return a + DESC_BYTES;
    endfunction
    task automatic run_one(input ettxd_desc_t d, input logic [31:0] a);
        logic [12:0] s1;
        logic [12:0] s2;
        logic [63:0] st;
        logic stp;
        int n;
        int k;
        s1 = d.w1[12:0];
        s2 = (d.w0[W0_CHAIN] | d.w1[W1_CHAIN]) ? 13'h0 : d.w1[28:16];
        n = int'(s1 != 13'h0) + int'(s2 != 13'h0);
        if (n == 0) d.w0[W0_STAMP_EN] = 1'b0;
        stp = stamp_on & d.w0[W0_STAMP_EN] & d.w0[W0_FS] & d.w0[W0_LS];
        st = {$urandom, $urandom};
        host.segq.delete();
        host.mem.delete();
        send(a, d);
        if (!d.w0[W0_OWN]) begin
            repeat (3) @(posedge sys_clk);
            check32(32'(host.mem.num()), 32'h0, "unowned writes");
            return;
        end
        k = 0;
        while (host.segq.size() < n && k++ < 300) @(negedge sys_clk);
        check32(32'(k > 300), 32'h0, "segment wait");
        if (n > 0) begin
            @(posedge sys_clk);
            tx_done <= 1'b1;
            tx_stamp <= st;
            @(posedge sys_clk);
            tx_done <= 1'b0;
        end
        k = 0;
        while (next_valid !== 1'b1 && k++ < 300) @(negedge sys_clk);
        check32(32'(k > 300), 32'h0, "release wait");
        check32(next_addr, nxt(d, a), "next address");
        check32(32'(host.segq.size()), 32'(n), "segments");
        if (s1 != 13'h0) begin
            check32(host.segq[0].addr, d.w2, "buf one addr");
            check32(32'(host.segq[0].size), 32'(s1), "buf one size");
            check32(32'(host.segq[0].last),
                32'(d.w0[W0_LS] & d.w0[W0_CHAIN]), "buf one last");
        end
        if (s2 != 13'h0) begin
            check32(host.segq[n-1].addr, d.w3, "buf two addr");
            check32(32'(host.segq[n-1].size), 32'(s2), "buf two size");
            check32(32'(host.segq[n-1].last),
                32'(d.w0[W0_LS]), "buf two last");
        end
        check32(host.mem[a], {1'b0, d.w0[30:0]}, "release");
        check32(32'(host.mem.exists(a + 32'h4)), 32'h0, "word 1");
        if (stp) begin
            check32(host.mem[a + W2_OFS], st[31:0], "stamp low");
            check32(host.mem[a + W3_OFS], st[63:32], "stamp high");
        end else
            check32(32'(host.mem.num()), 32'h1, "no stamp");
    endtask
    // Watchdog: far above the several hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        close_out();
    end
    initial begin
        ettxd_desc_t d;
        logic [31:0] r;
        void'($urandom(89));
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        reg_read(REG_CTRL, r);
        check32(r, 32'(CTRL_RESET), "control reset");
        reg_write(REG_RING, RING_BASE);
        reg_read(REG_RING, r);
        check32(r, RING_BASE, "ring base");
        reg_read(5'h14, r);
        check32(r, 32'h0, "unmapped read");
        reg_write(REG_CTRL, 32'h3);
        d = '0;
        run_one(d, 32'h0000_0100);
        reg_read(REG_STATUS, r);
        check32(32'(r[3]), 32'h1, "suspended");
        // Random descriptors with zero sizes forced in turn
        for (int i = 0; i < 40; i++) begin
            if (i == 20) stamp_on = 1'b0;
            if (i == 20) reg_write(REG_CTRL, 32'h2);
            d.w0 = 32'h8000_0000 | ($urandom & 32'h0230_0000);
            if ($urandom % 2) d.w0 |= 32'h3000_0000;
            d.w1 = $urandom;
            if (i % 4 == 0) d.w1[12:0] = 13'h0;
            if (i % 4 == 1) d.w1[28:16] = 13'h0;
            d.w2 = $urandom;
            d.w3 = $urandom & 32'hFFFF_FFF0;
            run_one(d, $urandom & 32'h000F_FFF0);
        end
        // Every loop descriptor is owned, so each one is released once
        reg_read(REG_COUNT, r);
        check32(r, 32'h0000_0028, "released count");
        close_out();
    end
endmodule // tb_top
